//--- hdl/aths_sequencer.sv
// Track/hold and conversion sequencer with input multiplexer routing
`timescale 1ns/1ns
module aths_sequencer #(
    parameter int CHANNELS = 12
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Serial link, from the pins
    input wire logic i_scl,
    // Frame events from the bus front end and the comparator level, same clock domain
    input wire logic i_frame_start,
    input wire logic i_addr_match,
    input wire logic i_read_dir,
    input wire logic i_byte_valid,
    input wire logic [7:0] i_byte_data,
    input wire logic i_result_start,
    input wire logic i_comparator,
    // Track/hold control and status
    output logic o_track,
    output logic o_hold,
    output logic o_converting,
    output logic o_scl_low_oe_n,
    output logic o_result_valid,
    output logic [11:0] o_result,
    // Multiplexer routing, shared pin mode and clock mode
    output logic [CHANNELS-1:0] o_pos_select,
    output logic [CHANNELS-1:0] o_neg_select,
    output logic o_neg_to_ground,
    output logic [1:0] o_ref_pin_mode,
    output logic o_internal_clock_mode
);
    typedef enum {
        ST_IDLE, ST_ADDR, ST_INT_TRACK, ST_INT_CONV, ST_EXT_WAIT, ST_EXT_TRACK, ST_EXT_CONV
    } aths_state_t;

    aths_state_t state;
    logic scl_meta;
    logic scl_sync;
    logic scl_prev;
    logic scl_rise;
    logic scl_fall;
    logic [3:0] edge_count;
    logic [3:0] bit_count;
    logic [3:0] div_count;
    logic int_tick;
    logic conv_tick;
    logic [7:0] setup_reg;
    logic [7:0] config_reg;
    logic [11:0] sar;
    logic [11:0] trial;
    aths_pkg::aths_th_state_t th;

    // Link clock passes two flops before its edges are found
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            scl_prev <= 1'b1;
        end else begin
            scl_meta <= i_scl;
            scl_sync <= scl_meta;
            scl_prev <= scl_sync;
        end
    end
    assign scl_rise = scl_sync & ~scl_prev;
    assign scl_fall = ~scl_sync & scl_prev;

    // Setup or configuration byte by its top bit
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            setup_reg <= aths_pkg::SETUP_RESET;
            config_reg <= aths_pkg::CONFIG_RESET;
        end else if (i_byte_valid) begin
            if (i_byte_data[aths_pkg::SETUP_FLAG_BIT]) begin
                setup_reg <= i_byte_data;
            end else begin
                config_reg <= i_byte_data;
            end
        end
    end

    // Internal conversion clock from a divider; only runs while converting
    always_ff @(posedge i_clk) begin
        if (i_reset || state != ST_INT_CONV) begin
            div_count <= 4'h0;
        end else if (div_count == aths_pkg::INT_CLK_DIV - 4'h1) begin
            div_count <= 4'h0;
        end else begin
            div_count <= div_count + 4'h1;
        end
    end
    assign int_tick = (state == ST_INT_CONV) && (div_count == aths_pkg::INT_CLK_DIV - 4'h1);
    // External mode converts on serial clock rising edges
    assign conv_tick = (state == ST_EXT_CONV) ? scl_rise : int_tick;
    assign trial = sar | (12'h800 >> bit_count);

    // Sequencer: track, hold and conversion phases
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state <= ST_IDLE;
            edge_count <= 4'h0;
            bit_count <= 4'h0;
            sar <= 12'h000;
            o_result <= 12'h000;
            o_result_valid <= 1'b0;
        end else begin
            o_result_valid <= 1'b0;
            case (state)
                ST_IDLE: begin
                    edge_count <= 4'h0;
                    if (i_frame_start) begin
                        state <= ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        edge_count <= edge_count + 4'h1;
                    end
                    // Mode from the stored setting
                    if (!setup_reg[aths_pkg::SETUP_CLK_BIT]) begin
                        if (scl_rise && edge_count == aths_pkg::ADDR_TRACK_BIT - 4'h1) begin
                            state <= ST_INT_TRACK;
                        end
                    end else if (scl_rise && edge_count == aths_pkg::ADDR_TRACK_BIT - 4'h1
                                 && i_addr_match && i_read_dir) begin
                        state <= ST_EXT_TRACK;
                    end else if (scl_rise && edge_count == aths_pkg::ADDR_TRACK_BIT - 4'h1) begin
                        state <= ST_IDLE;
                    end
                end
                ST_INT_TRACK: begin
                    // Track from rise 8 to fall of pulse 9: 1.5 serial periods
                    if (scl_rise) begin
                        edge_count <= edge_count + 4'h1;
                    end
                    if (scl_fall && edge_count == aths_pkg::ADDR_ACK_BIT) begin
                        state <= i_addr_match ? ST_INT_CONV : ST_IDLE;
                        bit_count <= 4'h0;
                        sar <= 12'h000;
                    end
                end
                ST_EXT_TRACK: begin
                    // Track from the direction bit to pulse 2 of result: 3 periods
                    edge_count <= 4'h0;
                    if (i_result_start) begin
                        state <= ST_EXT_WAIT;
                    end
                end
                ST_EXT_WAIT: begin
                    if (scl_rise) begin
                        edge_count <= edge_count + 4'h1;
                        if (edge_count == aths_pkg::EXT_HOLD_PULSE - 4'h1) begin
                            state <= ST_EXT_CONV;
                            bit_count <= 4'h0;
                            sar <= 12'h000;
                        end
                    end
                end
                ST_INT_CONV, ST_EXT_CONV: begin
                    // One bit decided per conversion clock
                    if (conv_tick) begin
                        sar <= i_comparator ? trial : sar;
                        bit_count <= bit_count + 4'h1;
                        if (bit_count == 4'(aths_pkg::CONV_CYCLES - 1)) begin
                            o_result <= i_comparator ? trial : sar;
                            o_result_valid <= 1'b1;
                            state <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Track/hold phase outputs, registered
    always_comb begin
        th.track = (state == ST_INT_TRACK) || (state == ST_EXT_TRACK) || (state == ST_EXT_WAIT);
        th.converting = (state == ST_INT_CONV) || (state == ST_EXT_CONV);
        th.hold = th.converting;
        th.scl_hold_low = (state == ST_INT_CONV);
    end
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_track <= 1'b0;
            o_hold <= 1'b0;
            o_converting <= 1'b0;
            o_scl_low_oe_n <= 1'b1;
        end else begin
            o_track <= th.track;
            o_hold <= th.hold;
            o_converting <= th.converting;
            o_scl_low_oe_n <= ~th.scl_hold_low;
        end
    end

    // Multiplexer routing; selects beyond the channel count stay open
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_pos_select <= '0;
            o_neg_select <= '0;
            o_neg_to_ground <= 1'b1;
            o_ref_pin_mode <= 2'h0;
            o_internal_clock_mode <= 1'b1;
        end else begin
            for (int k = 0; k < CHANNELS; k++) begin
                if (config_reg[aths_pkg::CFG_SGL_BIT]) begin
                    o_pos_select[k] <= (4'(k) == config_reg[aths_pkg::CFG_CS_LSB +: 4]);
                    o_neg_select[k] <= 1'b0;
                end else begin
                    // Pair index is the upper bits; low bit swaps polarity
                    o_pos_select[k] <= (4'(k >> 1) == {1'b0, config_reg[aths_pkg::CFG_CS_LSB+1 +: 3]})
                        && ((k % 2 == 1) == config_reg[aths_pkg::CFG_CS_LSB]);
                    o_neg_select[k] <= (4'(k >> 1) == {1'b0, config_reg[aths_pkg::CFG_CS_LSB+1 +: 3]})
                        && ((k % 2 == 1) != config_reg[aths_pkg::CFG_CS_LSB]);
                end
            end
            o_neg_to_ground <= config_reg[aths_pkg::CFG_SGL_BIT];
            // Shared pin: 0x input, 10 reference in, 11 reference out
            if (!setup_reg[aths_pkg::SETUP_SEL_LSB + 1]) begin
                o_ref_pin_mode <= 2'(aths_pkg::AT_MODE_ANALOG_INPUT);
            end else if (!setup_reg[aths_pkg::SETUP_SEL_LSB]) begin
                o_ref_pin_mode <= 2'(aths_pkg::AT_MODE_REF_INPUT);
            end else begin
                o_ref_pin_mode <= 2'(aths_pkg::AT_MODE_REF_OUTPUT);
            end
            o_internal_clock_mode <= ~setup_reg[aths_pkg::SETUP_CLK_BIT];
        end
    end
endmodule

//--- hdl/aths_pkg.sv
// Package: constants and carrier types for the track/hold sequencer
package aths_pkg;
    localparam int RESULT_BITS = 12;
    localparam int CONV_CYCLES = 12;
    localparam logic [3:0] ADDR_TRACK_BIT = 4'h8;
    localparam logic [3:0] ADDR_ACK_BIT = 4'h9;
    localparam logic [3:0] EXT_HOLD_PULSE = 4'h2;
    localparam logic [3:0] INT_CLK_DIV = 4'h4;
    localparam logic [7:0] SETUP_RESET = 8'h80;
    localparam logic [7:0] CONFIG_RESET = 8'h01;
    localparam int SETUP_FLAG_BIT = 7;
    localparam int CFG_SGL_BIT = 0;
    localparam int CFG_CS_LSB = 1;
    localparam int SETUP_SEL_LSB = 4;
    localparam int SETUP_CLK_BIT = 3;

    typedef enum logic [1:0] {
        AT_MODE_ANALOG_INPUT,
        AT_MODE_REF_INPUT,
        AT_MODE_REF_OUTPUT
    } aths_pin_mode_t;

    typedef struct packed {
        logic track;
        logic hold;
        logic converting;
        logic scl_hold_low;
    } aths_th_state_t;
endpackage

//--- sim/aths_sequencer_properties.sv
// Checker: port relations of the track/hold sequencer
`timescale 1ns/1ns
module aths_sequencer_props #(
    parameter int CHANNELS = 12
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Watched ports
    input wire logic i_byte_valid,
    input wire logic [7:0] i_byte_data,
    input wire logic o_track,
    input wire logic o_hold,
    input wire logic o_converting,
    input wire logic o_scl_low_oe_n,
    input wire logic o_result_valid,
    input wire logic [CHANNELS-1:0] o_pos_select,
    input wire logic [CHANNELS-1:0] o_neg_select,
    input wire logic o_neg_to_ground,
    input wire logic o_internal_clock_mode
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // Stretching belongs to internal conversions only
    property p_int_low; o_converting && o_internal_clock_mode |-> !o_scl_low_oe_n; endproperty
    a_int_low: assert property (p_int_low) else $error("scl not held low");
    property p_ext_free; !o_internal_clock_mode |-> o_scl_low_oe_n; endproperty
    a_ext_free: assert property (p_ext_free) else $error("scl driven in ext mode");
    property p_tr_hold; o_track |-> !o_hold; endproperty
    a_tr_hold: assert property (p_tr_hold) else $error("track and hold");
    property p_tr_start; $rose(o_track) |-> !o_converting; endproperty
    a_tr_start: assert property (p_tr_start) else $error("track while busy");
    // Twelve ticks of four clocks each
    property p_conv; $rose(o_converting) && o_internal_clock_mode |-> ##[44:52] o_result_valid;
    endproperty
    a_conv: assert property (p_conv) else $error("conversion length");
    property p_sgl; o_neg_to_ground |-> o_neg_select == '0 && $onehot0(o_pos_select); endproperty
    a_sgl: assert property (p_sgl) else $error("single-ended route");
    property p_dif; !o_neg_to_ground |-> $onehot(o_neg_select) && !(|(o_neg_select & o_pos_select));
    endproperty
    a_dif: assert property (p_dif) else $error("differential route");
    property p_cfg; i_byte_valid && !i_byte_data[7] |=> $stable(o_internal_clock_mode); endproperty
    a_cfg: assert property (p_cfg) else $error("config byte changed mode");
    property p_ext; i_byte_valid && i_byte_data[7] && i_byte_data[3] |-> ##[1:2]
        !o_internal_clock_mode; endproperty
    a_ext: assert property (p_ext) else $error("setup byte ignored");
endmodule
bind aths_sequencer aths_sequencer_props #(.CHANNELS(CHANNELS)) i_props (.i_clk(i_clk),
    .i_reset(i_reset), .i_byte_valid(i_byte_valid), .i_byte_data(i_byte_data),
    .o_track(o_track), .o_hold(o_hold), .o_converting(o_converting),
    .o_scl_low_oe_n(o_scl_low_oe_n), .o_result_valid(o_result_valid),
    .o_pos_select(o_pos_select), .o_neg_select(o_neg_select),
    .o_neg_to_ground(o_neg_to_ground), .o_internal_clock_mode(o_internal_clock_mode));

//--- sim/aths_scl_master.sv
// Serial clock master model: bursts of pulses, line idles high
`timescale 1ns/1ns
module aths_scl_master (
    // Request
    input wire logic i_start,
    input wire logic [5:0] i_pulses,
    // Wire level, low while the device stretches
    input wire logic i_wire,
    // Clock and status
    output logic o_scl,
    output logic o_busy
);
    initial begin
        o_scl = 1'b1;
        o_busy = 1'b0;
    end
    // A high half only starts once the wire is released, so stretching is honoured
    always @(posedge i_start) begin
        o_busy = 1'b1;
        repeat (i_pulses) begin
            o_scl = 1'b0;
            #63 o_scl = 1'b1;
            wait (i_wire);
            #62;
        end
        o_busy = 1'b0;
    end
endmodule

//--- sim/aths_sequencer_tb.sv
// Self-checking bench for the track/hold sequencer
`timescale 1ns/1ns
module aths_sequencer_tb;
    logic i_clk = 1'b0, i_reset = 1'b1, scl_m, start = 1'b0, busy, fs = 1'b0, rs = 1'b0;
    logic match = 1'b1, rd = 1'b1, bv = 1'b0, track, hold, conv, oe_n, rv, ntg, im;
    logic [7:0] bd = 8'h00;
    // Comparator level driven per scenario, so both result polarities are seen
    logic comp = 1'b1;
    logic [5:0] pulses = 6'h00;
    logic [11:0] result, pos, neg;
    logic [1:0] refmode;
    int err_total = 0, checked = 0, n;
    // Open-drain clock line with pull-up
    wire scl = scl_m & oe_n;
    aths_sequencer #(.CHANNELS(12)) i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_scl(scl),
        .i_frame_start(fs), .i_addr_match(match), .i_read_dir(rd), .i_byte_valid(bv),
        .i_byte_data(bd), .i_result_start(rs), .i_comparator(comp), .o_track(track),
        .o_hold(hold), .o_converting(conv), .o_scl_low_oe_n(oe_n), .o_result_valid(rv),
        .o_result(result), .o_pos_select(pos), .o_neg_select(neg), .o_neg_to_ground(ntg),
        .o_ref_pin_mode(refmode), .o_internal_clock_mode(im));
    aths_scl_master i_master (.i_start(start), .i_pulses(pulses), .i_wire(scl),
        .o_scl(scl_m), .o_busy(busy));
    initial forever #4 i_clk = ~i_clk;
    task automatic tick;
        @(posedge i_clk);
        #1;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] b);
        tick;
        bv = 1'b1;
        bd = b;
        tick;
        bv = 1'b0;
        tick;
    endtask
    // Launch a burst; frame start only with the address byte
    task automatic go(input logic [5:0] p, input logic f);
        pulses = p;
        start = 1'b1;
        fs = f;
        tick;
        start = 1'b0;
        fs = 1'b0;
    endtask
    task automatic idle;
        for (n = 0; n < 900 && busy !== 1'b0; n++) tick;
        // A burst that never ends means the line is stuck low
        if (n >= 900) err_total++;
    endtask
    task automatic t_route;
        for (int c = 0; c < 12; c++) begin
            wr({3'h0, c[3:0], 1'b1});
            cmp({3'h0, ntg, pos}, 16'h1000 | (16'h1 << c));
        end
        wr(8'h04);
        cmp({ntg, 3'h0, pos}, 16'h0004);
        cmp({4'h0, neg}, 16'h0008);
        wr(8'h87);
        cmp({2'h0, refmode, pos}, 16'h0004);
        wr(8'hb0);
        cmp({14'h0, refmode}, 16'h0002);
        wr(8'ha0);
        cmp({14'h0, refmode}, 16'h0001);
        $display("t_route done");
    endtask
    task automatic t_int;
        int w;
        wr(8'h01);
        go(6'd10, 1'b1);
        for (n = 0; n < 300 && track !== 1'b1; n++) tick;
        for (w = 0; w < 300 && track === 1'b1; w++) tick;
        cmp({15'h0, w >= 22 && w <= 25}, 16'h1);
        cmp({14'h0, hold, oe_n}, 16'h2);
        cmp({15'h0, conv}, 16'h1);
        for (n = 0; n < 300 && rv !== 1'b1; n++) tick;
        cmp({15'h0, rv}, 16'h1);
        cmp({4'h0, result}, 16'h0fff);
        idle();
        cmp({15'h0, oe_n}, 16'h1);
        // No match at the acknowledge: no stretch, so the burst keeps its plain length
        match = 1'b0;
        go(6'd10, 1'b1);
        idle();
        cmp({15'h0, n < 170}, 16'h1);
        cmp({13'h0, track, hold, oe_n}, 16'h0001);
        match = 1'b1;
        $display("t_int done");
    endtask
    task automatic t_ext;
        wr(8'h88);
        cmp({15'h0, im}, 16'h0);
        comp = 1'b0;
        rd = 1'b0;
        go(6'd9, 1'b1);
        idle();
        cmp({15'h0, track}, 16'h0);
        rd = 1'b1;
        go(6'd9, 1'b1);
        idle();
        cmp({14'h0, track, oe_n}, 16'h3);
        rs = 1'b1;
        tick;
        rs = 1'b0;
        go(6'd2, 1'b0);
        idle();
        cmp({14'h0, track, hold}, 16'h1);
        go(6'd12, 1'b0);
        for (n = 0; n < 300 && rv !== 1'b1; n++) tick;
        cmp({15'h0, n >= 178 && n <= 188}, 16'h1);
        cmp({4'h0, result}, 16'h0000);
        idle();
        $display("t_ext done");
    endtask
    task automatic end_of_test;
        $display("checked=%0d err_total=%0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge i_clk);
        #1 i_reset = 1'b0;
        cmp({12'h0, oe_n, ntg, im, track}, 16'h000e);
        t_route();
        t_int();
        t_ext();
        end_of_test();
    end
    // Watchdog well beyond the expected run
    initial begin
        #100000;
        err_total++;
        end_of_test();
    end
endmodule
